// ===== divn_clk_src.sv
`default_nettype none
module divn_clk_src #(
    parameter int HALF = 4
) (
    input  wire logic clk_i,
    input  wire logic run_i,
    output logic      cnt_clk_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_q = 1'b0;
    int   phase = 0;
    assign cnt_clk_o = clk_q;
    // The input clock parks low between bursts, so no stray edge reaches the counter.
    always @(posedge clk_i) begin
        if (run_i || clk_q) begin
            if (phase == HALF - 1) begin
                phase <= 0;
                clk_q <= !clk_q;
            end else begin
                phase <= phase + 1;
            end
        end
    end
endmodule : divn_clk_src
`default_nettype wire

// ===== divn_counter.sv
// Added by the designer: the placing of the registers and the APB interface to the registers.
`default_nettype none
// Operation
// RQ1: Divides input clock by N from 3 upward.
// RQ2: Output pulse one input cycle, every N.
// RQ3: Start count from sixteen preset bits.
// RQ4: Three mode selects set section moduli.
// RQ5: Each first-section cycle decrements upper sections.
// RQ6: Last section uses spare first-section flip-flops.
// RQ7: Mode 110 divides by ten, no last.
// RQ8: Mode 111: first by two, last by eight.
// RQ9: Mode 011: first by four, last by four.
// RQ10: Mode 101: first by five, last by two.
// RQ11: Mode 001: first by eight, last by two.
// RQ12: Divide-by-ten presets first up to nine.
// RQ13: Mid and high low force full preset.
// RQ14: Other side holds preset three clocks.
// RQ15: Other side presets before divide-by-five mode.
// RQ16: First edge after preset only arms counter.
// RQ17: Latch enable holds output high after pulse.
// RQ18: Terminal count reloads all sections from preset.
// RQ19: Divisor is modulus times upper plus first.
module divn_counter #(
    parameter int ADDR_W = 8
) (
    input  wire logic              SYS_CLK_I,
    input  wire logic              ARST_N_I,
    input  wire logic              CNT_CLK_I,
    input  wire logic              PSEL_I,
    input  wire logic              PENABLE_I,
    input  wire logic              PWRITE_I,
    input  wire logic [ADDR_W-1:0] PADDR_I,
    input  wire logic [31:0]       PWDATA_I,
    output logic      [31:0]       PRDATA_O,
    output logic                   PREADY_O,
    output logic                   PSLVERR_O,
    output logic                   DIV_OUT_O
);

    // The register offsets need at least eight address bits.
    if (ADDR_W < 8) begin : g_addr_w_chk
        $error("ADDR_W must be at least 8.");
    end

    ////////////////////////////////////////////////////////////////////////////////

    divn_pkg::ctrl_t       ctrl_ff;
    logic [15:0]           preset_ff;
    logic [31:0]           prdata_ff;
    logic                  slverr_ff;
    logic                  sync1_ff;
    logic                  sync2_ff;
    logic                  sync3_ff;
    logic                  level_ff;
    logic                  edge_seen;
    divn_pkg::run_state_t  state_ff;
    divn_pkg::run_state_t  nxt_state;
    divn_pkg::sections_t   sec_ff;
    divn_pkg::sections_t   nxt_sec;
    divn_pkg::sections_t   load_val;
    divn_pkg::first_mode_t first_mode;
    logic [3:0]            first_top;
    logic [2:0]            last_top;
    logic                  preset_mode;
    logic                  upper_zero;
    logic                  terminal;
    logic                  out_ff;
    logic                  latch_q_ff;
    logic                  latch_drop;
    logic                  setup;
    logic                  do_write;
    logic                  addr_hit;
    logic [31:0]           rd_mux;
    logic [7:0]            addr_lo;

    ////////////////////////////////////////////////////////////////////////////////
    // APB slave: zero wait states, read data captured in the setup cycle.
    // Unmapped addresses answer with an error, and writes to them are dropped.

    assign addr_lo  = PADDR_I[7:0];
    assign setup    = PSEL_I && !PENABLE_I;
    assign do_write = PSEL_I && PENABLE_I && PWRITE_I;
    assign addr_hit = (PADDR_I[ADDR_W-1:0] == ADDR_W'(addr_lo))
                   && ((addr_lo == divn_pkg::CTRL_OFS)   || (addr_lo == divn_pkg::PRESET_OFS)
                    || (addr_lo == divn_pkg::STATUS_OFS) || (addr_lo == divn_pkg::COUNT_OFS));

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (addr_lo)
            divn_pkg::CTRL_OFS: begin
                rd_mux[3:0] = ctrl_ff;
            end
            divn_pkg::PRESET_OFS: begin
                rd_mux[15:0] = preset_ff;
            end
            divn_pkg::STATUS_OFS: begin
                rd_mux[divn_pkg::STAT_OUT_BIT]    = out_ff;
                rd_mux[divn_pkg::STAT_PRESET_BIT] = state_ff == divn_pkg::ST_PRESET;
                rd_mux[divn_pkg::STAT_ARMED_BIT]  = state_ff == divn_pkg::ST_ARM;
                rd_mux[divn_pkg::STAT_COUNT_BIT]  = state_ff == divn_pkg::ST_COUNT;
            end
            divn_pkg::COUNT_OFS: begin
                rd_mux[divn_pkg::CNT_FIRST_LSB +: 4] = sec_ff.first;
                rd_mux[divn_pkg::CNT_DEC0_LSB +: 4]  = sec_ff.dec0;
                rd_mux[divn_pkg::CNT_DEC1_LSB +: 4]  = sec_ff.dec1;
                rd_mux[divn_pkg::CNT_DEC2_LSB +: 4]  = sec_ff.dec2;
                rd_mux[divn_pkg::CNT_LAST_LSB +: 3]  = sec_ff.last;
            end
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
        if (!addr_hit) begin
            rd_mux = 32'h0000_0000;
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            prdata_ff <= 32'h0000_0000;
            slverr_ff <= 1'b0;
        end else if (setup) begin
            prdata_ff <= PWRITE_I ? 32'h0000_0000 : rd_mux;
            slverr_ff <= !addr_hit;
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            ctrl_ff   <= divn_pkg::ctrl_t'(divn_pkg::CTRL_RST);
            preset_ff <= divn_pkg::PRESET_RST;
        end else if (do_write && addr_hit) begin
            if (addr_lo == divn_pkg::CTRL_OFS) begin
                ctrl_ff <= divn_pkg::ctrl_t'(PWDATA_I[3:0]);
            end
            if (addr_lo == divn_pkg::PRESET_OFS) begin
                preset_ff <= PWDATA_I[15:0]; // RQ3
            end
        end
    end

    assign PRDATA_O  = prdata_ff;
    assign PREADY_O  = 1'b1;
    assign PSLVERR_O = PSEL_I && PENABLE_I && slverr_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Input clock synchroniser; a rising level counts as an edge once stages two and three agree.

    always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            sync3_ff <= 1'b0;
            level_ff <= 1'b0;
        end else begin
            sync1_ff <= CNT_CLK_I;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            if (sync2_ff == sync3_ff) begin
                level_ff <= sync3_ff;
            end
        end
    end

    // The level starts low like the parked pin, so reset gives no false edge.
    assign edge_seen = (sync2_ff == sync3_ff) && sync3_ff && !level_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Mode decode and preset split.

    assign preset_mode = !ctrl_ff.mode_select_mid && !ctrl_ff.mode_select_high; // RQ13

    // Mode 010 is not a listed code and falls back to divide by ten.
    always_comb begin
        first_mode = divn_pkg::FIRST_DIV10;
        unique case ({ctrl_ff.mode_select_low, ctrl_ff.mode_select_mid,
                      ctrl_ff.mode_select_high}) // RQ4
            3'b111: first_mode = divn_pkg::FIRST_DIV2;  // RQ8
            3'b011: first_mode = divn_pkg::FIRST_DIV4;  // RQ9
            3'b101: first_mode = divn_pkg::FIRST_DIV5;  // RQ10
            3'b001: first_mode = divn_pkg::FIRST_DIV8;  // RQ11
            default: first_mode = divn_pkg::FIRST_DIV10; // RQ7
        endcase
    end

    always_comb begin
        load_val      = '0;
        load_val.dec0 = preset_ff[7:4];
        load_val.dec1 = preset_ff[11:8];
        load_val.dec2 = preset_ff[15:12];
        first_top     = divn_pkg::TOP_DIV10;
        last_top      = divn_pkg::LTOP_DIV1;
        unique case (first_mode) // RQ6
            divn_pkg::FIRST_DIV2: begin
                first_top      = divn_pkg::TOP_DIV2;
                last_top       = divn_pkg::LTOP_DIV8;
                load_val.first = {3'h0, preset_ff[0]};
                load_val.last  = preset_ff[3:1]; // RQ8
            end
            divn_pkg::FIRST_DIV4: begin
                first_top      = divn_pkg::TOP_DIV4;
                last_top       = divn_pkg::LTOP_DIV4;
                load_val.first = {2'h0, preset_ff[1:0]};
                load_val.last  = {1'b0, preset_ff[3:2]}; // RQ9
            end
            divn_pkg::FIRST_DIV5: begin
                first_top      = divn_pkg::TOP_DIV5;
                last_top       = divn_pkg::LTOP_DIV2;
                load_val.first = {1'b0, preset_ff[2:0]};
                load_val.last  = {2'h0, preset_ff[3]}; // RQ10
            end
            divn_pkg::FIRST_DIV8: begin
                first_top      = divn_pkg::TOP_DIV8;
                last_top       = divn_pkg::LTOP_DIV2;
                load_val.first = {1'b0, preset_ff[2:0]};
                load_val.last  = {2'h0, preset_ff[3]}; // RQ11
            end
            divn_pkg::FIRST_DIV10: begin
                first_top      = divn_pkg::TOP_DIV10;
                last_top       = divn_pkg::LTOP_DIV1;
                load_val.first = preset_ff[3:0];
                load_val.last  = 3'h0; // RQ12
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Down-counter. The remaining count is first + modulus * (upper sections), so
    // one step per input edge from the loaded value gives a period of N edges.

    assign upper_zero = (sec_ff.dec0 == 4'h0) && (sec_ff.dec1 == 4'h0)
                     && (sec_ff.dec2 == 4'h0) && (sec_ff.last == 3'h0);
    assign terminal   = upper_zero && (sec_ff.first <= 4'h1); // RQ19

    always_comb begin
        nxt_sec = sec_ff;
        if (terminal) begin
            nxt_sec = load_val; // RQ18
        end else if (sec_ff.first != 4'h0) begin
            nxt_sec.first = sec_ff.first - 4'h1; // RQ1
        end else begin
            nxt_sec.first = first_top; // RQ5
            if (sec_ff.dec0 != 4'h0) begin
                nxt_sec.dec0 = sec_ff.dec0 - 4'h1;
            end else begin
                nxt_sec.dec0 = divn_pkg::DECADE_TOP;
                if (sec_ff.dec1 != 4'h0) begin
                    nxt_sec.dec1 = sec_ff.dec1 - 4'h1;
                end else begin
                    nxt_sec.dec1 = divn_pkg::DECADE_TOP;
                    if (sec_ff.dec2 != 4'h0) begin
                        nxt_sec.dec2 = sec_ff.dec2 - 4'h1;
                    end else begin
                        nxt_sec.dec2 = divn_pkg::DECADE_TOP;
                        nxt_sec.last = (sec_ff.last != 3'h0) ? sec_ff.last - 3'h1 : last_top;
                    end
                end
            end
        end
    end

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            divn_pkg::ST_PRESET: begin
                if (!preset_mode) begin
                    nxt_state = divn_pkg::ST_ARM;
                end
            end
            divn_pkg::ST_ARM: begin
                if (preset_mode) begin
                    nxt_state = divn_pkg::ST_PRESET;
                end else if (edge_seen) begin
                    nxt_state = divn_pkg::ST_COUNT; // RQ16
                end
            end
            divn_pkg::ST_COUNT: begin
                if (preset_mode) begin
                    nxt_state = divn_pkg::ST_PRESET;
                end
            end
            default: begin
                nxt_state = divn_pkg::ST_PRESET;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            state_ff <= divn_pkg::ST_PRESET;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // A divide mode splits the low preset nibble between first and last section
    // differently from the preset decode, so the sections reload under the new
    // split until counting starts; the arming edge therefore only arms.
    always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            sec_ff <= '0;
        end else if (preset_mode || state_ff != divn_pkg::ST_COUNT) begin
            sec_ff <= load_val; // RQ13
        end else if (edge_seen && state_ff == divn_pkg::ST_COUNT) begin
            sec_ff <= nxt_sec; // RQ5
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Output: set on the terminal edge and cleared on the next input edge. While
    // latching it stays high; releasing the latch clears it on the next cycle
    // rather than waiting for an input edge.

    // Remembers the latch enable of the previous cycle, so that a release is
    // seen as soon as it is written.
    always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            latch_q_ff <= 1'b0;
        end else begin
            latch_q_ff <= ctrl_ff.latch_en;
        end
    end

    assign latch_drop = latch_q_ff && !ctrl_ff.latch_en;

    always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            out_ff <= 1'b0;
        end else if (preset_mode) begin
            out_ff <= 1'b0;
        end else if (edge_seen && state_ff == divn_pkg::ST_COUNT && terminal) begin
            out_ff <= 1'b1; // RQ2
        end else if (ctrl_ff.latch_en) begin
            out_ff <= out_ff; // RQ17
        end else if (edge_seen || latch_drop
                     || (out_ff && state_ff != divn_pkg::ST_COUNT)) begin
            out_ff <= 1'b0; // RQ17
        end
    end

    assign DIV_OUT_O = out_ff;

endmodule : divn_counter
`default_nettype wire

// ===== divn_counter_props.sv
`default_nettype none
module divn_counter_props #(
    parameter int ADDR_W = 8
) (
    input wire logic              SYS_CLK_I,
    input wire logic              ARST_N_I,
    input wire logic              CNT_CLK_I,
    input wire logic              PSEL_I,
    input wire logic              PENABLE_I,
    input wire logic              PWRITE_I,
    input wire logic [ADDR_W-1:0] PADDR_I,
    input wire logic [31:0]       PWDATA_I,
    input wire logic [31:0]       PRDATA_O,
    input wire logic              PREADY_O,
    input wire logic              PSLVERR_O,
    input wire logic              DIV_OUT_O
);
    logic [3:0] ctrl_ff;
    logic [1:0] cclk_ff;
    logic [3:0] edge_ago_ff;
    logic       wr_ctrl;
    logic       unmapped;
    assign wr_ctrl  = PSEL_I && PENABLE_I && PWRITE_I && (PADDR_I == ADDR_W'(divn_pkg::CTRL_OFS));
    assign unmapped = !(PADDR_I inside {ADDR_W'(divn_pkg::CTRL_OFS), ADDR_W'(divn_pkg::PRESET_OFS),
                                        ADDR_W'(divn_pkg::STATUS_OFS), ADDR_W'(divn_pkg::COUNT_OFS)});
    ////////////////////////////////////////////////////////////////////////////////////////////
    // Shadow of the control register and the age of the last input clock edge.
    always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            ctrl_ff <= 4'h0;
        end else if (wr_ctrl) begin
            ctrl_ff <= PWDATA_I[3:0];
        end
    end
    always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            cclk_ff     <= 2'h0;
            edge_ago_ff <= 4'hF;
        end else begin
            cclk_ff     <= {cclk_ff[0], CNT_CLK_I};
            edge_ago_ff <= (cclk_ff == 2'h1) ? 4'h0
                         : ((edge_ago_ff == 4'hF) ? 4'hF : edge_ago_ff + 4'h1);
        end
    end
    ////////////////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (!ARST_N_I);
    sequence access_s;
        PSEL_I && PENABLE_I;
    endsequence
    sequence free_pulse_s;
        $rose(DIV_OUT_O) && !ctrl_ff[3];
    endsequence
    bad_addr_err_a: assert property (access_s ##0 unmapped |-> PSLVERR_O)
        else $error("unmapped access without error response");
    good_addr_ok_a: assert property (access_s ##0 !unmapped |-> !PSLVERR_O)
        else $error("mapped access answered with error");
    bad_addr_rd_a: assert property (access_s ##0 (unmapped && !PWRITE_I) |-> PRDATA_O == 32'h0)
        else $error("unmapped read returned nonzero data");
    preset_quiet_a: assert property ((ctrl_ff[2:1] == 2'h0) [*2] |-> !DIV_OUT_O)
        else $error("output high while held in full preset");
    pulse_width_a: assert property (free_pulse_s |-> DIV_OUT_O [*5] ##[1:12] !DIV_OUT_O)
        else $error("output pulse not one input cycle wide");
    latch_hold_a: assert property (ctrl_ff[3] && DIV_OUT_O && !wr_ctrl |=> DIV_OUT_O)
        else $error("latched output dropped while latch enabled");
    latch_free_a: assert property (wr_ctrl && ctrl_ff[3] && !PWDATA_I[3] && DIV_OUT_O
                                   |-> ##[1:2] !DIV_OUT_O)
        else $error("latched output not released");
    rise_on_edge_a: assert property ($rose(DIV_OUT_O) |-> edge_ago_ff inside {[0:7]})
        else $error("output rose without a recent input clock edge");
endmodule : divn_counter_props
bind divn_counter divn_counter_props #(.ADDR_W(ADDR_W)) i_divn_counter_props (
    .SYS_CLK_I(SYS_CLK_I), .ARST_N_I(ARST_N_I), .CNT_CLK_I(CNT_CLK_I), .PSEL_I(PSEL_I),
    .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
    .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .DIV_OUT_O(DIV_OUT_O));
`default_nettype wire

// ===== divn_pkg.sv
`default_nettype none
package divn_pkg;

    // Register byte offsets.
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] PRESET_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    localparam logic [7:0] COUNT_OFS  = 8'h0C;

    // Control register field positions.
    localparam int CTRL_MODE_LOW_BIT  = 0;
    localparam int CTRL_MODE_MID_BIT  = 1;
    localparam int CTRL_MODE_HIGH_BIT = 2;
    localparam int CTRL_LATCH_BIT     = 3;

    // Status register field positions.
    localparam int STAT_OUT_BIT    = 0;
    localparam int STAT_PRESET_BIT = 1;
    localparam int STAT_ARMED_BIT  = 2;
    localparam int STAT_COUNT_BIT  = 3;

    // Count register field positions.
    localparam int CNT_FIRST_LSB  = 0;
    localparam int CNT_DEC0_LSB   = 4;
    localparam int CNT_DEC1_LSB   = 8;
    localparam int CNT_DEC2_LSB   = 12;
    localparam int CNT_LAST_LSB   = 16;

    // Reset values.
    localparam logic [3:0]  CTRL_RST   = 4'h0;
    localparam logic [15:0] PRESET_RST = 16'h0000;

    // Divider limits.
    localparam int N_MIN = 3;
    localparam int N_MAX = 15999;

    // First-section moduli minus one.
    localparam logic [3:0] TOP_DIV2  = 4'h1;
    localparam logic [3:0] TOP_DIV4  = 4'h3;
    localparam logic [3:0] TOP_DIV5  = 4'h4;
    localparam logic [3:0] TOP_DIV8  = 4'h7;
    localparam logic [3:0] TOP_DIV10 = 4'h9;

    // Last-section moduli minus one.
    localparam logic [2:0] LTOP_DIV8 = 3'h7;
    localparam logic [2:0] LTOP_DIV4 = 3'h3;
    localparam logic [2:0] LTOP_DIV2 = 3'h1;
    localparam logic [2:0] LTOP_DIV1 = 3'h0;

    localparam logic [3:0] DECADE_TOP = 4'h9;

    typedef enum logic [4:0] {
        FIRST_DIV2  = 5'b00001,
        FIRST_DIV4  = 5'b00010,
        FIRST_DIV5  = 5'b00100,
        FIRST_DIV8  = 5'b01000,
        FIRST_DIV10 = 5'b10000
    } first_mode_t;

    typedef enum logic [2:0] {
        ST_PRESET = 3'b001,
        ST_ARM    = 3'b010,
        ST_COUNT  = 3'b100
    } run_state_t;

    typedef struct packed {
        logic latch_en;
        logic mode_select_high;
        logic mode_select_mid;
        logic mode_select_low;
    } ctrl_t;

    typedef struct packed {
        logic [2:0] last;
        logic [3:0] dec2;
        logic [3:0] dec1;
        logic [3:0] dec0;
        logic [3:0] first;
    } sections_t;

endpackage : divn_pkg
`default_nettype wire

// ===== test_programmable_divide_by_n_counter.sv
`default_nettype none
module test_programmable_divide_by_n_counter;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [2:0] MODES [5] = '{3'h7, 3'h6, 3'h5, 3'h4, 3'h3};
    localparam int         FMOD  [5] = '{2, 4, 5, 8, 10};
    localparam int         FMAX  [5] = '{1, 3, 4, 7, 9};
    logic        sys_clk = 1'b0;
    logic        arst_n  = 1'b0;
    logic        run     = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        div_out;
    logic        cnt_clk;
    int          n_fail = 0;
    int          checks_done = 0;
    int          edges = 0;
    int          pulses = 0;
    int          cycles = 0;
    int          exp_q[$];
    divn_counter #(.ADDR_W(8)) i_divn_counter (
        .SYS_CLK_I(sys_clk), .ARST_N_I(arst_n), .CNT_CLK_I(cnt_clk), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .DIV_OUT_O(div_out));
    divn_clk_src #(.HALF(4)) i_divn_clk_src (.clk_i(sys_clk), .run_i(run), .cnt_clk_o(cnt_clk));
    always #5 sys_clk = ~sys_clk;
    ////////////////////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude
    task automatic check(input logic [31:0] seen, input logic [31:0] expd);
        checks_done++;
        if (seen !== expd) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, expd);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                       output logic [31:0] rdat, output logic serr);
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rdat = prdata;
        serr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic acc(input logic wr, input logic [7:0] addr, input logic [31:0] d,
                       input logic err_exp);
        logic [31:0] rdat;
        logic        serr;
        apb(wr, addr, d, rdat, serr);
        check({31'h0, serr}, {31'h0, err_exp});
        if (!wr) check(rdat, d);
    endtask : acc
    // Presets, shows the preset state, then counts N+1 edges and reps further periods of N.
    task automatic run_mode(input logic [3:0] ctrl, input logic [15:0] pre, input int n,
                            input int reps);
        acc(1'b1, divn_pkg::CTRL_OFS, 32'h0, 1'b0);
        acc(1'b1, divn_pkg::PRESET_OFS, {16'h0, pre}, 1'b0);
        acc(1'b0, divn_pkg::PRESET_OFS, {16'h0, pre}, 1'b0);
        run <= 1'b1;
        repeat (3) @(posedge cnt_clk);
        @(posedge sys_clk) run <= 1'b0;
        repeat (12) @(posedge sys_clk);
        acc(1'b0, divn_pkg::STATUS_OFS, 32'h2, 1'b0);
        acc(1'b0, divn_pkg::COUNT_OFS, {16'h0, pre}, 1'b0);
        acc(1'b1, divn_pkg::CTRL_OFS, {28'h0, ctrl}, 1'b0);
        acc(1'b0, divn_pkg::STATUS_OFS, 32'h4, 1'b0);
        edges = 0;
        pulses = 0;
        exp_q.push_back(n + 1);
        repeat (reps) exp_q.push_back(n);
        @(posedge sys_clk) run <= 1'b1;
        wait (pulses == reps + 1);
        if (!ctrl[3]) begin
            wait (div_out === 1'b0);
            @(posedge sys_clk) run <= 1'b0;
        end
    endtask : run_mode
    ////////////////////////////////////////////////////////////////////////////////////////////
    always @(posedge cnt_clk) edges = edges + 1;
    always @(posedge div_out) begin
        pulses++;
        if (exp_q.size() > 0) begin
            check(32'(edges), 32'(exp_q.pop_front()));
        end else begin
            check(32'h1, 32'h0);
        end
        edges = 0;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 95000) begin
            n_fail++;
            conclude();
        end
    end
    initial begin
        int          f;
        int          d0;
        int          d1;
        int          lst;
        logic [15:0] pre;
        void'($urandom(7007));
        repeat (10) @(posedge sys_clk);
        arst_n <= 1'b1;
        acc(1'b0, divn_pkg::CTRL_OFS, 32'h0, 1'b0);
        acc(1'b0, divn_pkg::PRESET_OFS, 32'h0, 1'b0);
        acc(1'b0, 8'h10, 32'h0, 1'b1);
        acc(1'b1, 8'h10, 32'h5, 1'b1);
        acc(1'b1, divn_pkg::STATUS_OFS, 32'hF, 1'b0);
        acc(1'b1, divn_pkg::CTRL_OFS, 32'h1, 1'b0);
        acc(1'b0, divn_pkg::STATUS_OFS, 32'h2, 1'b0);
        for (int i = 0; i < 5; i++) begin
            f   = $urandom_range(FMAX[i]);
            d0  = $urandom_range(9, 2);
            d1  = $urandom_range(1);
            lst = (i == 0) ? 1 : 0;
            pre = {4'h0, 4'(d1), 4'(d0), (i == 0) ? {3'h1, 1'(f)} : 4'(f)};
            // Expected divisor from the section moduli and place values.
            run_mode({1'b0, MODES[i]}, pre, FMOD[i] * (1000 * lst + 10 * d1 + d0) + f,
                     1);
        end
        run_mode(4'hA, 16'h0035, 35, 0);
        repeat (80) @(posedge cnt_clk);
        check({31'h0, div_out}, 32'h1);
        acc(1'b0, divn_pkg::STATUS_OFS, 32'h9, 1'b0);
        acc(1'b1, divn_pkg::CTRL_OFS, 32'h2, 1'b0);
        repeat (3) @(posedge sys_clk);
        check({31'h0, div_out}, 32'h0);
        acc(1'b1, divn_pkg::CTRL_OFS, 32'h0, 1'b0);
        @(posedge sys_clk) run <= 1'b0;
        repeat (20) @(posedge sys_clk);
        conclude();
    end
endmodule : test_programmable_divide_by_n_counter
`default_nettype wire
